// ### core/uabw_autobaud_wake.sv
// Notes on behaviour
// - Receive line times divisor counter on sync character.
// - Enable starts calibration, receiver held idle.
// - Count from first rise to fifth rise.
// - Fifth rise: keep count, clear enable, flag.
// - Both divisor bytes form one 16-bit counter.
// - Measurement clock is base clock divided eight.
// - Base and measurement rates follow speed selects.
// - Counter starts at one; software subtracts one.
// - Overflow sets flag, counting continues to end.
// - Overflow clear needs enable cleared first.
// - Buffer read clears receive flag after measure.
// - Small counts leave high byte at zero.
// - Wake enable holds receiver idle, watching line.
// - Wake function only in asynchronous mode.
// - Falling edge sets receive flag, also asleep.
// - Rising edge ending break clears wake enable.
// - Both enables: measure byte after break.
// - Non-zero character: first low time wakes.
// - Sleep stops counter; wake detection and edge sequencing still run.
`default_nettype none
module uabw_autobaud_wake #(
    parameter int unsigned DIV_W = uabw_pkg::DIV_W
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    serial_in_line_in,
    input  wire logic                    async_mode_in,
    input  wire logic                    sleep_in,
    input  wire logic                    wide_divisor_select_in,
    input  wire logic                    high_speed_select_in,
    input  wire logic                    autobaud_enable_set_in,
    input  wire logic                    autobaud_enable_clr_in,
    input  wire logic                    wake_on_break_enable_set_in,
    input  wire logic                    wake_on_break_enable_clr_in,
    input  wire logic                    autobaud_overflow_clr_in,
    input  wire logic                    receive_buffer_read_in,
    input  wire logic                    divisor_write_in,
    input  wire logic [DIV_W-1:0]        divisor_wdata_in,
    output logic                         autobaud_enable_out,
    output logic                         wake_on_break_enable_out,
    output logic                         autobaud_overflow_flag_out,
    output logic                         receive_flag_out,
    output logic [7:0]                   divisor_high_byte_out,
    output logic [7:0]                   divisor_low_byte_out,
    output logic                         receiver_hold_idle_out,
    output logic                         base_tick_out,
    output logic                         wake_request_out
);
    import uabw_pkg::*;

    if (DIV_W != 16) begin : g_bad_width
        $error("uabw_autobaud_wake: DIV_W must be 16");
    end

    uabw_tick_if tick_if ();

    // Divider for the base rate and the one-eighth measurement rate.
    uabw_prescaler #(
        .PRE_W (PRE_W)
    ) u_prescaler (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .tick_if    (tick_if)
    );

    // Sleep stops the divider and with it the divisor counter.
    assign tick_if.wide_sel = wide_divisor_select_in;
    assign tick_if.high_sel = high_speed_select_in;
    assign tick_if.run      = !sleep_in;
    assign base_tick_out    = tick_if.base_tick;

    // Line synchroniser; only the second stage and its delayed copy are compared.
    logic rx_meta_q;
    logic rx_sync_q;
    logic rx_prev_q;
    logic rx_fall;
    logic rx_rise;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rx_meta_q <= LINE_IDLE;
            rx_sync_q <= LINE_IDLE;
            rx_prev_q <= LINE_IDLE;
        end else begin
            rx_meta_q <= serial_in_line_in;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    assign rx_fall = rx_prev_q && !rx_sync_q;
    assign rx_rise = !rx_prev_q && rx_sync_q;

    // Control and status flags.
    logic                 abd_en_q;
    logic                 abd_en_d;
    logic                 wob_en_q;
    logic                 wob_en_d;
    logic                 wake_seen_q;
    logic                 wake_seen_d;
    logic                 ovf_q;
    logic                 ovf_d;
    logic                 rcv_flag_q;
    logic                 rcv_flag_d;
    logic [DIV_W-1:0]     div_q;
    logic [DIV_W-1:0]     div_d;
    logic [2:0]           rises_q;
    logic [2:0]           rises_d;
    uabw_ab_state_t       ab_state_q;
    uabw_ab_state_t       ab_state_d;

    // Wake event decode and break end.
    logic wake_event;
    logic break_end;
    assign wake_event = wob_en_q && !wake_seen_q && rx_fall;
    assign break_end  = wob_en_q && wake_seen_q && rx_rise;

    // During sleep the wake request is raised straight from the pin, with no clock.
    assign wake_request_out = sleep_in && wob_en_q && !serial_in_line_in;

    // Measurement decode; the sequencer waits while a break is still being watched.
    logic ab_active;
    logic count_tick;
    logic last_rise;
    logic counting;
    logic count_wrap;
    assign ab_active  = abd_en_q && !wob_en_q;
    assign counting   = ab_active && (ab_state_q == UABW_AB_COUNT);
    assign count_tick = counting && tick_if.detect_tick;
    assign last_rise  = counting && rx_rise && (rises_q == RISES_TO_END - 3'h1);
    assign count_wrap = count_tick && !last_rise && (div_q == COUNT_MAX);

    // Measurement sequencer.
    always_comb begin
        ab_state_d = ab_state_q;
        rises_d    = rises_q;
        unique case (ab_state_q)
            UABW_AB_IDLE: begin
                if (ab_active) begin
                    ab_state_d = UABW_AB_START;
                end
            end
            UABW_AB_START: begin
                if (!ab_active) begin
                    ab_state_d = UABW_AB_IDLE;
                end else if (rx_fall) begin
                    ab_state_d = UABW_AB_FIRST;
                end
            end
            UABW_AB_FIRST: begin
                if (!ab_active) begin
                    ab_state_d = UABW_AB_IDLE;
                end else if (rx_rise) begin
                    ab_state_d = UABW_AB_COUNT;
                    rises_d    = 3'h1;
                end
            end
            UABW_AB_COUNT: begin
                if (!ab_active || last_rise) begin
                    ab_state_d = UABW_AB_IDLE;
                end else if (rx_rise) begin
                    rises_d = rises_q + 3'h1;
                end
            end
        endcase
    end

    // Divisor pair: software write, or the measurement counter as one 16-bit word.
    always_comb begin
        div_d = div_q;
        if (ab_active && ab_state_q == UABW_AB_FIRST && rx_rise) begin
            div_d = COUNT_START;
        end else if (count_tick && !last_rise) begin
            div_d = div_q + 16'h0001;           // wraps to zero past the top.
        end else if (divisor_write_in && !counting) begin
            div_d = divisor_wdata_in;
        end
    end

    // Flag next values; a hardware set of the overflow or receive flag wins over a clear in the same cycle.
    always_comb begin
        abd_en_d = abd_en_q;
        if (last_rise) begin
            abd_en_d = 1'b0;
        end
        if (autobaud_enable_clr_in) begin
            abd_en_d = 1'b0;
        end
        if (autobaud_enable_set_in) begin
            abd_en_d = 1'b1;
        end

        wob_en_d    = wob_en_q;
        wake_seen_d = wake_seen_q;
        if (wake_event) begin
            wake_seen_d = 1'b1;
        end
        if (break_end || wake_on_break_enable_clr_in || !async_mode_in) begin
            wob_en_d    = 1'b0;
            wake_seen_d = 1'b0;
        end
        if (wake_on_break_enable_set_in && async_mode_in && !wob_en_q) begin
            wob_en_d    = 1'b1;
            wake_seen_d = 1'b0;
        end

        ovf_d = ovf_q;
        if (autobaud_overflow_clr_in && !abd_en_q) begin
            ovf_d = 1'b0;
        end
        if (count_wrap) begin
            ovf_d = 1'b1;
        end

        rcv_flag_d = rcv_flag_q;
        if (receive_buffer_read_in) begin
            rcv_flag_d = 1'b0;
        end
        if (last_rise || wake_event) begin
            rcv_flag_d = 1'b1;
        end
    end

    // State registers.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ab_state_q  <= UABW_AB_IDLE;
            rises_q     <= 3'h0;
            div_q       <= DIVISOR_RESET;
            abd_en_q    <= 1'b0;
            wob_en_q    <= 1'b0;
            wake_seen_q <= 1'b0;
            ovf_q       <= 1'b0;
            rcv_flag_q  <= 1'b0;
        end else begin
            ab_state_q  <= ab_state_d;
            rises_q     <= rises_d;
            div_q       <= div_d;
            abd_en_q    <= abd_en_d;
            wob_en_q    <= wob_en_d;
            wake_seen_q <= wake_seen_d;
            ovf_q       <= ovf_d;
            rcv_flag_q  <= rcv_flag_d;
        end
    end

    // Outputs; the normal receiver is held idle while either mode is armed.
    assign autobaud_enable_out        = abd_en_q;
    assign wake_on_break_enable_out   = wob_en_q;
    assign autobaud_overflow_flag_out = ovf_q;
    assign receive_flag_out           = rcv_flag_q;
    assign divisor_high_byte_out      = div_q[15:8];
    assign divisor_low_byte_out       = div_q[7:0];
    assign receiver_hold_idle_out     = abd_en_q || wob_en_q;

    // Checks on the design's own behaviour.
    // All of them are quiet while reset is held, so no history from before release is judged.
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_final_rise;
        counting && rx_rise && rises_q == 3'h4 && !autobaud_enable_set_in;
    endsequence
    sequence s_done;
        !abd_en_q && rcv_flag_q;
    endsequence
    sequence s_first_rise;
        ab_active && ab_state_q == UABW_AB_FIRST && rx_rise;
    endsequence
    // A wake edge that no software clear or mode change cancels in the same cycle.
    sequence s_wake_kept;
        wake_event && async_mode_in && !wake_on_break_enable_clr_in;
    endsequence
    sequence s_stay_clear;
        !wob_en_q ##1 (!wob_en_q || $past(wake_on_break_enable_set_in));
    endsequence

    measure_done_a: assert property (s_final_rise |=> s_done)
        else $error("measurement end did not clear enable and set flag");
    count_start_a: assert property (s_first_rise |=> div_q == 16'h0001 && ab_state_q == UABW_AB_COUNT)
        else $error("counter did not start at one on first rise");
    count_step_a: assert property (count_tick && !last_rise |=> div_q == $past(div_q) + 16'h0001)
        else $error("counter did not step on measurement tick");
    hold_count_a: assert property (counting && !tick_if.detect_tick && !last_rise |=> $stable(div_q))
        else $error("counter moved without a measurement tick");
    overflow_set_a: assert property (count_wrap |=> ovf_q && div_q == 16'h0000)
        else $error("overflow not flagged on wrap");
    overflow_keep_a: assert property (ovf_q && abd_en_q && !count_wrap |=> ovf_q)
        else $error("overflow cleared while enable still set");
    idle_hold_a: assert property (abd_en_q || wob_en_q |-> receiver_hold_idle_out)
        else $error("receiver not held idle");
    wake_flag_a: assert property (s_wake_kept |=> rcv_flag_q && wob_en_q)
        else $error("wake edge did not set receive flag");
    break_end_a: assert property (break_end |=> s_stay_clear)
        else $error("break end did not clear wake enable");
    async_only_a: assert property (!async_mode_in |=> !wob_en_q)
        else $error("wake enabled outside asynchronous mode");
    read_clear_a: assert property (receive_buffer_read_in && !last_rise && !wake_event |=> !rcv_flag_q)
        else $error("buffer read did not clear receive flag");
    sleep_freeze_a: assert property (sleep_in |-> !count_tick)
        else $error("counter ticked during sleep");
    wait_break_a: assert property (abd_en_q && wob_en_q |=> ab_state_q == UABW_AB_IDLE)
        else $error("measurement ran before break ended");

    // Measurement sequencer steps, from start bit to fifth rise.
    sequence s_start_fall;
        ab_active && ab_state_q == UABW_AB_START && rx_fall;
    endsequence
    sequence s_wait_rise;
        ab_active && ab_state_q == UABW_AB_FIRST && !rx_rise;
    endsequence

    start_fall_a: assert property (s_start_fall |=> ab_state_q == UABW_AB_FIRST)
        else $error("start bit did not arm the first rise wait");
    first_wait_a: assert property (s_wait_rise |=> ab_state_q == UABW_AB_FIRST)
        else $error("sequencer left the first rise wait early");
    count_stay_a: assert property (counting && !last_rise |=> ab_state_q == UABW_AB_COUNT)
        else $error("measurement ended before the fifth rise");
    rise_range_a: assert property (ab_state_q == UABW_AB_COUNT |-> rises_q > 3'h0 && rises_q < RISES_TO_END)
        else $error("rise count out of range while counting");
    rise_step_a: assert property (counting && rx_rise && !last_rise |=> rises_q == $past(rises_q) + 3'h1)
        else $error("rise count did not advance on a rise");
    meas_stop_a: assert property (!ab_active |=> ab_state_q == UABW_AB_IDLE)
        else $error("sequencer ran without an armed measurement");

    // Counter, divisor pair and divider ticks.
    sequence s_free_write;
        divisor_write_in && ab_state_q != UABW_AB_COUNT && !rx_rise;
    endsequence

    wrap_go_on_a: assert property (count_wrap |=> ab_state_q == UABW_AB_COUNT)
        else $error("measurement stopped at counter wrap");
    high_zero_a: assert property (count_tick && !last_rise && div_q < 16'h00ff |=> div_q[15:8] == 8'h00)
        else $error("small count disturbed the high byte");
    sleep_hold_a: assert property (sleep_in && counting |=> $stable(div_q))
        else $error("counter moved during sleep");
    detect_base_a: assert property (tick_if.detect_tick |-> tick_if.base_tick)
        else $error("measurement tick off the base clock grid");
    base_pulse_a: assert property (tick_if.base_tick |=> !tick_if.base_tick)
        else $error("base tick longer than one cycle");
    write_land_a: assert property (s_free_write |=> div_q == $past(divisor_wdata_in))
        else $error("divisor write did not land as one pair");

    // Software controls and flags.
    enable_start_a: assert property (autobaud_enable_set_in |=> abd_en_q && receiver_hold_idle_out)
        else $error("enable set did not arm the measurement");
    ovf_clear_a: assert property (autobaud_overflow_clr_in && !abd_en_q && !count_wrap |=> !ovf_q)
        else $error("overflow clear ignored with enable clear");
    wake_low_a: assert property (s_wake_kept |=> wake_seen_q)
        else $error("first low time not taken as the wake event");
endmodule // uabw_autobaud_wake
`default_nettype wire

// ### core/uabw_pkg.sv
`default_nettype none
package uabw_pkg;
    // Width of the divisor pair used as one counter during measurement.
    localparam int unsigned DIV_W          = 16;
    // Prescaler width, enough for the slowest measurement clock of Fosc/512.
    localparam int unsigned PRE_W          = 9;
    // Prescaler masks: a tick fires when all masked bits of the free counter are ones.
    localparam logic [8:0]  BASE_MASK_FAST = 9'h003;  // Fosc/4.
    localparam logic [8:0]  BASE_MASK_MID  = 9'h00f;  // Fosc/16.
    localparam logic [8:0]  BASE_MASK_SLOW = 9'h03f;  // Fosc/64.
    localparam logic [8:0]  DET_MASK_FAST  = 9'h01f;  // Fosc/32.
    localparam logic [8:0]  DET_MASK_MID   = 9'h07f;  // Fosc/128.
    localparam logic [8:0]  DET_MASK_SLOW  = 9'h1ff;  // Fosc/512.
    localparam logic [8:0]  PRE_RESET      = 9'h000;
    // Measurement constants.
    localparam logic [7:0]  SYNC_CHAR      = 8'h55;   // Character the remote end sends.
    localparam logic [2:0]  RISES_TO_END   = 3'h5;    // Fifth rising edge ends the measure.
    localparam logic [15:0] COUNT_START    = 16'h0001;
    localparam logic [15:0] COUNT_MAX      = 16'hffff;
    localparam logic [15:0] DIVISOR_RESET  = 16'h0000;
    localparam logic        LINE_IDLE      = 1'b1;

    // Measurement sequencer states.
    typedef enum logic [1:0] {
        UABW_AB_IDLE  = 2'b00,
        UABW_AB_START = 2'b01,
        UABW_AB_FIRST = 2'b10,
        UABW_AB_COUNT = 2'b11
    } uabw_ab_state_t;
endpackage
`default_nettype wire

// ### core/uabw_tick_if.sv
`default_nettype none
interface uabw_tick_if;
    logic wide_sel;
    logic high_sel;
    logic run;
    logic base_tick;
    logic detect_tick;
    modport ctrl (output wide_sel, output high_sel, output run, input base_tick, input detect_tick);
    modport gen  (input wide_sel, input high_sel, input run, output base_tick, output detect_tick);
endinterface
`default_nettype wire

// ### core/uabw_prescaler.sv
`default_nettype none
module uabw_prescaler #(
    parameter int unsigned PRE_W = uabw_pkg::PRE_W
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    uabw_tick_if.gen  tick_if
);
    import uabw_pkg::*;

    if (PRE_W < 9) begin : g_bad_width
        $error("uabw_prescaler: PRE_W must be at least 9");
    end

    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_d;
    logic [8:0]       base_mask;
    logic [8:0]       det_mask;
    logic [1:0]       sel_cnt;

    // Number of the two speed selects that are set picks the rate pair.
    assign sel_cnt   = {1'b0, tick_if.wide_sel} + {1'b0, tick_if.high_sel};
    assign base_mask = (sel_cnt == 2'h2) ? BASE_MASK_FAST : (sel_cnt == 2'h1) ? BASE_MASK_MID : BASE_MASK_SLOW;
    assign det_mask  = (sel_cnt == 2'h2) ? DET_MASK_FAST : (sel_cnt == 2'h1) ? DET_MASK_MID : DET_MASK_SLOW;
    assign pre_d     = tick_if.run ? pre_q + 1'b1 : pre_q;

    // Ticks are one-cycle enables; both stay low while the divider is stopped.
    assign tick_if.base_tick   = tick_if.run && ((pre_q[8:0] & base_mask) == base_mask);
    assign tick_if.detect_tick = tick_if.run && ((pre_q[8:0] & det_mask) == det_mask);

    // Free-running prescaler, frozen while stopped.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end
endmodule // uabw_prescaler
`default_nettype wire

// ### sim/uabw_remote_tx.sv
`default_nettype none
// Far-end serial transmitter; the line is driven high while idle.
module uabw_remote_tx (
    input  wire logic ref_clk_in,
    output var logic  line_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // The line starts idle so that no false start bit is seen after reset.
    initial line_out = 1'b1;

    // Holds one level for n clocks, changing it just after a rising edge.
    task automatic send_level(input logic v, input int n);
        @(posedge ref_clk_in);
        line_out <= v;
        repeat (n - 1) @(posedge ref_clk_in);
    endtask

    // Sends a start bit, eight data bits lowest first, then a stop bit.
    task automatic send_byte(input logic [7:0] b, input int p);
        send_level(1'b0, p);
        for (int i = 0; i < 8; i++) begin
            send_level(b[i], p);
        end
        send_level(1'b1, p);
    endtask
endmodule // uabw_remote_tx
`default_nettype wire

// ### sim/uabw_autobaud_and_break_wake_tb.sv
`default_nettype none
module uabw_autobaud_and_break_wake_tb;
    import uabw_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int         LIMIT   = 60000;
    localparam logic [6:0] AB_SET  = 7'h01;
    localparam logic [6:0] AB_CLR  = 7'h02;
    localparam logic [6:0] WK_SET  = 7'h04;
    localparam logic [6:0] OVF_CLR = 7'h10;
    localparam logic [6:0] RD      = 7'h20;
    localparam logic [6:0] DIV_WR  = 7'h40;

    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        async_mode = 1'b1;
    logic        sleep   = 1'b0;
    logic        wide    = 1'b1;
    logic        high    = 1'b1;
    logic [6:0]  ctl     = 7'h00;
    logic [15:0] wdata   = 16'h0000;
    logic        line;
    logic        ab_en;
    logic        wk_en;
    logic        ovf;
    logic        rxf;
    logic [7:0]  hi_byte;
    logic [7:0]  lo_byte;
    logic        hold;
    logic        tick;
    logic        wreq;
    wire  logic [15:0] div_pair = {hi_byte, lo_byte};
    int          failures   = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    // Clock at 20 MHz.
    always #25 ref_clk = ~ref_clk;

    uabw_remote_tx u_tx (.ref_clk_in(ref_clk), .line_out(line));

    uabw_autobaud_wake u_dut (
        .ref_clk_in(ref_clk), .rst_in(rst), .serial_in_line_in(line), .async_mode_in(async_mode),
        .sleep_in(sleep), .wide_divisor_select_in(wide), .high_speed_select_in(high),
        .autobaud_enable_set_in(ctl[0]), .autobaud_enable_clr_in(ctl[1]),
        .wake_on_break_enable_set_in(ctl[2]), .wake_on_break_enable_clr_in(ctl[3]),
        .autobaud_overflow_clr_in(ctl[4]), .receive_buffer_read_in(ctl[5]),
        .divisor_write_in(ctl[6]), .divisor_wdata_in(wdata),
        .autobaud_enable_out(ab_en), .wake_on_break_enable_out(wk_en),
        .autobaud_overflow_flag_out(ovf), .receive_flag_out(rxf),
        .divisor_high_byte_out(hi_byte), .divisor_low_byte_out(lo_byte),
        .receiver_hold_idle_out(hold), .base_tick_out(tick), .wake_request_out(wreq)
    );

    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares a measured count against a window of one tick either way.
    task automatic check_in(input logic [15:0] got, input logic [15:0] lo_v, input logic [15:0] hi_v);
        n_compared++;
        if ((got >= lo_v && got <= hi_v) !== 1'b1) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo_v, hi_v);
        end
    endtask

    // Raises the given control pulses for one cycle; outputs have settled on return.
    task automatic pulse(input logic [6:0] m);
        @(posedge ref_clk);
        ctl <= m;
        @(posedge ref_clk);
        ctl <= 7'h00;
        #1;
    endtask

    // Reports the counts and ends the run.
    task automatic print_verdict();
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Flags clear out of reset; an idle divisor write lands as one pair.
    task automatic reset_values();
        check({11'h000, ab_en, wk_en, ovf, rxf, hold}, 16'h0000);
        check(div_pair, DIVISOR_RESET);
        @(posedge ref_clk);
        wdata <= 16'h1234;
        pulse(DIV_WR);
        check(div_pair, 16'h1234);
    endtask

    // Measures a sync character four clock periods of the detection rate per bit.
    task automatic measure(input int mode);
        int d;
        int n;
        d = (mode == 0) ? 32 : (mode == 3) ? 512 : 128;
        @(posedge ref_clk);
        wide <= (mode < 2);
        high <= (mode % 2 == 0);
        repeat (2) @(posedge ref_clk);
        for (n = 0; n < 600 && tick !== 1'b1; n++) @(posedge ref_clk);
        @(posedge ref_clk);
        for (n = 1; n < 600 && tick !== 1'b1; n++) @(posedge ref_clk);
        check(n[15:0], d[18:3]);
        pulse(AB_SET);
        check({14'h0000, ab_en, hold}, 16'h0003);
        u_tx.send_byte(SYNC_CHAR, 4 * d);
        check({14'h0000, ab_en, rxf}, 16'h0001);
        check({8'h00, hi_byte}, 16'h0000);
        check_in(div_pair, 16'h0020, 16'h0022);
        pulse(RD);
        check({15'h0000, rxf}, 16'h0000);
    endtask

    // Aborting a calibration: enable cleared first, then the overflow flag.
    task automatic abort_cal();
        pulse(AB_SET);
        pulse(AB_CLR);
        check({14'h0000, ab_en, hold}, 16'h0000);
        pulse(OVF_CLR);
        check({15'h0000, ovf}, 16'h0000);
    endtask

    // A break during sleep requests wake; its end clears the wake enable.
    task automatic wake_sleep();
        check({15'h0000, hold}, 16'h0000);
        @(posedge ref_clk);
        sleep <= 1'b1;
        pulse(WK_SET);
        check({14'h0000, wk_en, hold}, 16'h0003);
        u_tx.send_level(1'b0, 13 * 64);
        #1;
        check({15'h0000, wreq}, 16'h0001);
        @(posedge ref_clk);
        sleep <= 1'b0;
        u_tx.send_level(1'b1, 8);
        #1;
        check({13'h0000, wk_en, wreq, rxf}, 16'h0001);
        pulse(RD);
        check({15'h0000, rxf}, 16'h0000);
    endtask

    // Both enables together: the byte after the break is measured.
    task automatic wake_then_measure();
        @(posedge ref_clk);
        wide <= 1'b1;
        high <= 1'b1;
        pulse(WK_SET | AB_SET);
        u_tx.send_level(1'b0, 13 * 128);
        check({14'h0000, wk_en, rxf}, 16'h0003);
        u_tx.send_level(1'b1, 256);
        check({14'h0000, wk_en, ab_en}, 16'h0001);
        pulse(RD);
        u_tx.send_byte(SYNC_CHAR, 128);
        check({14'h0000, ab_en, rxf}, 16'h0001);
        check_in(div_pair, 16'h0020, 16'h0022);
        pulse(RD);
    endtask

    // Wake is refused outside asynchronous mode; a non-zero character wakes on its first low time.
    task automatic wake_modes();
        @(posedge ref_clk);
        async_mode <= 1'b0;
        pulse(WK_SET);
        check({15'h0000, wk_en}, 16'h0000);
        @(posedge ref_clk);
        async_mode <= 1'b1;
        pulse(WK_SET);
        u_tx.send_byte(8'hf0, 64);
        check({13'h0000, wk_en, ab_en, rxf}, 16'h0001);
        pulse(RD);
    endtask

    // Main sequence: reset for five cycles, then every scenario.
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        reset_values();
        for (int i = 0; i < 4; i++) begin
            measure(i);
        end
        abort_cal();
        wake_sleep();
        wake_then_measure();
        wake_modes();
        print_verdict();
    end

    // Cuts a hang short and counts it as a mismatch.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            print_verdict();
        end
    end
endmodule // uabw_autobaud_and_break_wake_tb
`default_nettype wire
